// file: rtl/dpc_pkg.sv
// Shared constants, types and timing figures for the dual pot command decoder
package dpc_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 4;

  // Longest stored-setting write time and longest wiper settle time
  localparam int NV_WRITE_MS = 5;
  localparam int WIPER_SETTLE_US = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WIPER_SETTLE_CYCLES = WIPER_SETTLE_US * 1000 / CLK_PERIOD_NS;

  // Geometry
  localparam int POTS = 2;
  localparam int SETTINGS = 4;
  localparam int WIPER_W = 6;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
  localparam logic [WIPER_W-1:0] WIPER_STEP = 6'h01;

  // Address byte layout
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 4;
  localparam int ADDR_RSV_MSB = 3;
  localparam int ADDR_RSV_LSB = 2;
  localparam int ADDR_SEL_MSB = 1;
  localparam int ADDR_SEL_LSB = 0;
  localparam logic [1:0] ADDR_RSV_VAL = 2'h0;

  // Instruction opcodes
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET = 4'hB;
  localparam logic [3:0] OP_WR_SET = 4'hC;
  localparam logic [3:0] OP_SET_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER_TO_SET = 4'hE;
  localparam logic [3:0] OP_GLB_SET_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GLB_WIPER_TO_SET = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;

  // Misc field values
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Instruction byte fields
  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] setting_sel; // setting_select_hi, setting_select_lo
    logic zero_bit;
    logic pot_select_bit;
  } dpc_instr_s;

  // Stored-setting write waiting for chip select to rise
  typedef struct packed {
    logic valid;
    logic global_all;
    logic from_wiper;
    logic pot;
    logic [1:0] setting_sel;
    logic [WIPER_W-1:0] data;
  } dpc_nv_job_s;

  // Frame states
  typedef enum logic [2:0] {
    DPC_IDLE = 3'b000,
    DPC_ADDR = 3'b001,
    DPC_INSTR = 3'b010,
    DPC_DATA = 3'b011,
    DPC_STEP = 3'b100,
    DPC_SKIP = 3'b101
  } dpc_state_e;

endpackage

// file: rtl/dpc_pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module dpc_pin_sync
  import dpc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by the second

  // Two flip-flops per bit; reset value is zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule

// file: rtl/dpc_top.sv
// Serial command decoder for a dual 64-step digital potentiometer
//
// Contract
// - Instruction: opcode, setting pointer, zero, pot bit
// - Opcode 1001 reads the pot's wiper position
// - Opcode 1010 writes the wiper position
// - Opcode 1011 reads the chosen stored setting
// - Opcode 1100 writes the chosen stored setting
// - Opcode 1101 copies stored setting to wiper
// - Opcode 1110 copies wiper into stored setting
// - Opcode 0001 copies settings to all wipers
// - Opcode 1000 copies all wipers into settings
// - Opcode 0010 enters step mode for one pot
// - Opcode 0101 returns the write pending bit
// - Four six-bit stored settings per pot
// - Stored setting write lasts at most 5 ms
// - Save starts when chip select rises
// - Write pending reads one during save
// - Read/write commands use three-byte frames
// - Copy commands use two-byte frames
// - Wiper output follows after settle delay
// - Wiper-to-setting copy is a timed save
// - First byte carries fixed device type code
// - Address bits match pins, upper pair zero
// - Power-up loads wipers from setting zero
// - Step mode moves wiper by serial input
`timescale 1ns/100ps
module dpc_top
  import dpc_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h3, // Device type code; value is arbitrary
  parameter int NV_CYCLES = NV_WRITE_CYCLES,
  parameter int SETTLE_CYCLES = WIPER_SETTLE_CYCLES,
  parameter logic [WIPER_W-1:0] SETTING_INIT = 6'h20
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic [1:0] addr_pin,
  output logic so,
  output logic so_oe,
  output logic [WIPER_W-1:0] wiper0,
  output logic [WIPER_W-1:0] wiper1,
  output logic write_pending
);

  localparam int NV_W = $clog2(NV_CYCLES + 1);
  localparam int ST_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [NV_W-1:0] NV_LAST = NV_W'(NV_CYCLES - 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(SETTLE_CYCLES - 1);

  // Synchronised pins and their previous values
  logic [4:0] pins_s;
  logic cs_n_s, sck_s, si_s;
  logic [1:0] addr_s;
  logic cs_n_p, sck_p;
  logic sck_rise, sck_fall, cs_rise, cs_fall;

  // Frame decoder state
  dpc_state_e state_q, state_d;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] byte_d;
  logic byte_done;
  dpc_instr_s instr_q;
  dpc_instr_s instr_d;
  logic [7:0] tx_q;
  logic reading_q;

  // Potentiometer storage
  logic [WIPER_W-1:0] wiper_q [POTS];
  logic [WIPER_W-1:0] setting_q [POTS][SETTINGS];
  logic [WIPER_W-1:0] wiper_out_q [POTS];
  logic power_up_q;

  // Save job and timer
  dpc_nv_job_s job_q;
  logic [NV_W-1:0] nv_cnt_q;
  logic pending_q;

  // Decoded actions on the wipers, the save job and the read data
  logic [POTS-1:0] wiper_ld;
  logic [WIPER_W-1:0] wiper_val [POTS];
  logic job_set;
  dpc_nv_job_s job_new;
  logic [7:0] tx_load;
  logic tx_ld, rd_start;

  // Address byte check
  function automatic logic addr_match(input logic [7:0] b, input logic [1:0] pins);
    addr_match = (b[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE) &&
                 (b[ADDR_RSV_MSB:ADDR_RSV_LSB] == ADDR_RSV_VAL) &&
                 (b[ADDR_SEL_MSB:ADDR_SEL_LSB] == pins);
  endfunction

  // Saturating single step of a wiper
  function automatic logic [WIPER_W-1:0] step_wiper(input logic [WIPER_W-1:0] w, input logic up);
    if (up)
      step_wiper = (w == WIPER_MAX) ? w : w + WIPER_STEP;
    else
      step_wiper = (w == WIPER_MIN) ? w : w - WIPER_STEP;
  endfunction

  // Pin synchronisers for chip select, clock, data and address straps
  dpc_pin_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({~cs_n, sck, si, addr_pin}), // Select enters inverted so reset reads as deselected
    .pin_sync(pins_s)
  );

  assign cs_n_s = ~pins_s[4]; // Idle high from reset on, so no false frame start
  assign sck_s = pins_s[3];
  assign si_s = pins_s[2];
  assign addr_s = pins_s[1:0];

  // Previous synchronised levels for edge finding; chip select idles high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cs_n_p <= 1'b1;
      sck_p <= 1'b0;
    end
    else
    begin
      cs_n_p <= cs_n_s;
      sck_p <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_p & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_p & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_n_p;
  assign cs_fall = ~cs_n_s & cs_n_p;
  assign byte_done = sck_rise && (bit_cnt_q == BIT_LAST);
  assign byte_d = {shift_q, si_s};
  assign instr_d = byte_d;

  // Bit counter and input shift register, cleared at each frame start
  always_ff @(posedge clk)
  begin
    if (rst || cs_fall)
    begin
      bit_cnt_q <= BIT_FIRST;
      shift_q <= '0;
    end
    else if (sck_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= byte_d[6:0];
    end
  end

  // Next frame state
  always_comb
  begin
    state_d = state_q;
    if (cs_n_s)
      state_d = DPC_IDLE; // Frame over
    else if (cs_fall)
      state_d = DPC_ADDR; // New frame
    else if (byte_done)
    begin
      unique case (state_q)
        DPC_ADDR:
          state_d = addr_match(byte_d, addr_s) ? DPC_INSTR : DPC_SKIP;
        DPC_INSTR:
        begin
          // Three-byte commands wait for data, copies end here
          state_d = DPC_SKIP;
          if (instr_d.zero_bit == 1'b0)
          begin
            unique case (instr_d.opcode)
              OP_RD_WIPER, OP_WR_WIPER:
                state_d = (instr_d.setting_sel == SEL_ZERO) ? DPC_DATA : DPC_SKIP;
              OP_RD_SET, OP_WR_SET:
                state_d = DPC_DATA;
              OP_STATUS:
                state_d = (instr_d.setting_sel == SEL_ZERO && instr_d.pot_select_bit) ? DPC_DATA : DPC_SKIP;
              OP_STEP:
                state_d = (instr_d.setting_sel == SEL_ZERO) ? DPC_STEP : DPC_SKIP;
              default:
                state_d = DPC_SKIP;
            endcase
          end
        end
        DPC_DATA:
          state_d = DPC_SKIP; // Extra bytes are ignored
        DPC_STEP:
          state_d = DPC_STEP; // Step mode lasts until chip select rises
        DPC_IDLE, DPC_SKIP:
          state_d = state_q;
        default:
          state_d = DPC_SKIP;
      endcase
    end
  end

  // Frame state register and latched instruction byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= DPC_IDLE;
      instr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (byte_done && state_q == DPC_INSTR)
        instr_q <= instr_d;
    end
  end

  // Decoded effects of each completed byte and of each step-mode clock rise
  always_comb
  begin
    wiper_ld = '0;
    for (int p = 0; p < POTS; p++)
      wiper_val[p] = wiper_q[p];
    job_set = 1'b0;
    job_new = '0;
    tx_ld = 1'b0;
    tx_load = BYTE_ZERO;
    rd_start = 1'b0;
    if (byte_done && state_q == DPC_INSTR && instr_d.zero_bit == 1'b0)
    begin
      unique case (instr_d.opcode)
        OP_RD_WIPER:
        begin
          tx_ld = 1'b1;
          rd_start = (instr_d.setting_sel == SEL_ZERO);
          tx_load = {2'h0, wiper_q[instr_d.pot_select_bit]};
        end
        OP_RD_SET:
        begin
          tx_ld = 1'b1;
          rd_start = 1'b1;
          tx_load = {2'h0, setting_q[instr_d.pot_select_bit][instr_d.setting_sel]};
        end
        OP_STATUS:
        begin
          tx_ld = 1'b1;
          rd_start = (instr_d.setting_sel == SEL_ZERO) && instr_d.pot_select_bit;
          tx_load = {7'h00, pending_q};
        end
        OP_SET_TO_WIPER:
        begin
          wiper_ld[instr_d.pot_select_bit] = 1'b1;
          wiper_val[instr_d.pot_select_bit] = setting_q[instr_d.pot_select_bit][instr_d.setting_sel];
        end
        OP_GLB_SET_TO_WIPER:
        begin
          if (instr_d.pot_select_bit == 1'b0)
          begin
            for (int p = 0; p < POTS; p++)
            begin
              wiper_ld[p] = 1'b1;
              wiper_val[p] = setting_q[p][instr_d.setting_sel];
            end
          end
        end
        OP_WIPER_TO_SET:
        begin
          job_set = 1'b1;
          job_new = '{valid: 1'b1, global_all: 1'b0, from_wiper: 1'b1,
                      pot: instr_d.pot_select_bit, setting_sel: instr_d.setting_sel, data: '0};
        end
        OP_GLB_WIPER_TO_SET:
        begin
          job_set = (instr_d.pot_select_bit == 1'b0);
          job_new = '{valid: 1'b1, global_all: 1'b1, from_wiper: 1'b1,
                      pot: 1'b0, setting_sel: instr_d.setting_sel, data: '0};
        end
        default:
        begin
          tx_ld = 1'b0;
        end
      endcase
    end
    else if (byte_done && state_q == DPC_DATA && !reading_q)
    begin
      if (instr_q.opcode == OP_WR_WIPER)
      begin
        wiper_ld[instr_q.pot_select_bit] = 1'b1;
        wiper_val[instr_q.pot_select_bit] = byte_d[WIPER_W-1:0];
      end
      else if (instr_q.opcode == OP_WR_SET)
      begin
        job_set = 1'b1;
        job_new = '{valid: 1'b1, global_all: 1'b0, from_wiper: 1'b0,
                    pot: instr_q.pot_select_bit, setting_sel: instr_q.setting_sel,
                    data: byte_d[WIPER_W-1:0]};
      end
    end
    else if (sck_rise && state_q == DPC_STEP)
    begin
      wiper_ld[instr_q.pot_select_bit] = 1'b1;
      wiper_val[instr_q.pot_select_bit] = step_wiper(wiper_q[instr_q.pot_select_bit], si_s);
    end
  end

  // Wiper position registers; loaded from setting zero after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      power_up_q <= 1'b1;
      for (int p = 0; p < POTS; p++)
        wiper_q[p] <= WIPER_MIN;
    end
    else if (power_up_q)
    begin
      power_up_q <= 1'b0;
      for (int p = 0; p < POTS; p++)
        wiper_q[p] <= setting_q[p][SEL_ZERO];
    end
    else
    begin
      for (int p = 0; p < POTS; p++)
        if (wiper_ld[p])
          wiper_q[p] <= wiper_val[p];
    end
  end

  // Held save job; a new one is refused while a save runs or one is held
  always_ff @(posedge clk)
  begin
    if (rst || cs_rise)
      job_q <= '0; // Consumed or dropped when the frame ends
    else if (job_set && !pending_q && !job_q.valid)
      job_q <= job_new;
  end

  // Stored settings, written only when chip select rises after a full write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int p = 0; p < POTS; p++)
        for (int s = 0; s < SETTINGS; s++)
          setting_q[p][s] <= SETTING_INIT;
    end
    else if (cs_rise && job_q.valid)
    begin
      for (int p = 0; p < POTS; p++)
        if (job_q.global_all || job_q.pot == p[0])
          setting_q[p][job_q.setting_sel] <= job_q.from_wiper ? wiper_q[p] : job_q.data;
    end
  end

  // Save timer; write pending stays high for the whole save
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pending_q <= 1'b0;
      nv_cnt_q <= '0;
    end
    else if (cs_rise && job_q.valid)
    begin
      pending_q <= 1'b1;
      nv_cnt_q <= '0;
    end
    else if (pending_q)
    begin
      if (nv_cnt_q == NV_LAST)
        pending_q <= 1'b0;
      else
        nv_cnt_q <= nv_cnt_q + NV_W'(1);
    end
  end

  assign write_pending = pending_q;

  // Read data shifter; bits leave on the falling clock edge, MSB first
  always_ff @(posedge clk)
  begin
    if (rst || cs_n_s)
    begin
      tx_q <= BYTE_ZERO;
      reading_q <= 1'b0;
      so <= 1'b0;
    end
    else if (tx_ld)
    begin
      tx_q <= tx_load;
      reading_q <= rd_start;
    end
    else if (sck_fall && state_q == DPC_DATA && reading_q)
    begin
      so <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
    else if (state_q == DPC_SKIP)
      reading_q <= 1'b0;
  end

  assign so_oe = reading_q && (state_q == DPC_DATA);

  // Wiper outputs follow their registers after the settle delay
  for (genvar g = 0; g < POTS; g++)
  begin : g_settle
    logic [ST_W-1:0] settle_cnt_q;
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        settle_cnt_q <= '0;
        wiper_out_q[g] <= WIPER_MIN;
      end
      else if (power_up_q)
        settle_cnt_q <= '0;
      else if (wiper_q[g] != wiper_out_q[g])
      begin
        if (settle_cnt_q == ST_LAST)
        begin
          wiper_out_q[g] <= wiper_q[g];
          settle_cnt_q <= '0;
        end
        else
          settle_cnt_q <= settle_cnt_q + ST_W'(1);
      end
      else
        settle_cnt_q <= '0;
    end
  end

  assign wiper0 = wiper_out_q[0];
  assign wiper1 = wiper_out_q[1];

endmodule

// file: verification/dpc_top_props.sv
// Concurrent checks on the pins of the pot command decoder
`timescale 1ns/100ps
module dpc_top_props
  import dpc_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES,
  parameter int SETTLE_CYCLES = WIPER_SETTLE_CYCLES,
  parameter logic [WIPER_W-1:0] SETTING_INIT = 6'h20
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic [1:0] addr_pin,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [WIPER_W-1:0] wiper0,
  input wire logic [WIPER_W-1:0] wiper1,
  input wire logic write_pending
);
  // Margin past the settle delay before the wipers must be quiet
  localparam int INIT_HI = SETTLE_CYCLES + 6;
  int pend_cnt; // Cycles the save has stood
  int cs_hi_cnt; // Cycles chip select has stood idle, saturating

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // Counts the length of each save
  always_ff @(posedge clk)
  begin
    if (rst || !write_pending)
      pend_cnt <= 0;
    else
      pend_cnt <= pend_cnt + 1;
  end

  // Counts idle time between frames
  always_ff @(posedge clk)
  begin
    if (rst || !cs_n)
      cs_hi_cnt <= 0;
    else if (cs_hi_cnt < 1000)
      cs_hi_cnt <= cs_hi_cnt + 1;
  end

  chk_pend_bound: assert property (write_pending |-> pend_cnt < NV_CYCLES)
    else $error("save lasted too long");
  chk_pend_cs_rise: assert property ($rose(write_pending) |-> cs_n && $past(cs_n, 2))
    else $error("save began before deselect");
  chk_pend_in_frame: assert property (!cs_n [*4] |-> !$rose(write_pending))
    else $error("save began inside a frame");
  chk_pend_holds: assert property ($rose(write_pending) |=> write_pending [*8])
    else $error("pending dropped early");
  chk_oe_idle: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
  chk_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 3))
    else $error("output enabled outside a frame");
  chk_wiper_quiet: assert property (cs_hi_cnt > INIT_HI |-> $stable(wiper0) && $stable(wiper1))
    else $error("wiper moved while idle");
  chk_wiper_init: assert property ($fell(rst) |-> ##[1:INIT_HI] (wiper0 == SETTING_INIT && wiper1 == SETTING_INIT))
    else $error("wipers not loaded from setting zero");

  cover property ($rose(write_pending));
  cover property ($rose(so_oe));
  cover property (!cs_n && $changed(wiper0));
endmodule
bind dpc_top dpc_top_props #(.NV_CYCLES(NV_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES), .SETTING_INIT(SETTING_INIT))
  i_dpc_top_props (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .addr_pin(addr_pin), .so(so),
  .so_oe(so_oe), .wiper0(wiper0), .wiper1(wiper1), .write_pending(write_pending));

// file: verification/dpc_spi_master.sv
// Behavioural serial master that frames commands for the decoder
`timescale 1ns/100ps
module dpc_spi_master
  import dpc_pkg::*;
(
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si
);
  // Idle bus: deselected, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Shifts nbits of tx out MSB first, samples so at each rise
  task automatic frame(input int nbits, input logic [31:0] tx, output logic [7:0] rx);
    rx = BYTE_ZERO;
    cs_n = 1'b0;
    #62.5;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      si = tx[i];
      #62.5;
      sck = 1'b1;
      rx = {rx[6:0], so};
      #62.5;
      sck = 1'b0;
    end
    #62.5;
    cs_n = 1'b1;
    si = ~si;
    #375;
  endtask
endmodule

// file: verification/dpc_top_test.sv
// Self-checking bench for the dual pot serial command decoder
`timescale 1ns/100ps
module dpc_top_test
  import dpc_pkg::*;
;
  localparam logic [3:0] TYPE_ID = 4'h6; // Device type code; value is arbitrary
  localparam int NV = 2000; // Short save so the run stays brief
  localparam int SETTLE = 8; // Short wiper settle delay
  localparam logic [1:0] PINS = 2'h2;
  localparam logic [7:0] ADDR = {TYPE_ID, 2'h0, PINS};
  logic clk, rst, cs_n, sck, si, so, so_oe, write_pending;
  logic [1:0] addr_pin;
  logic [WIPER_W-1:0] wiper0, wiper1;
  logic [7:0] rx;
  logic [7:0] bad [3] = '{ADDR ^ 8'h80, ADDR ^ 8'h04, ADDR ^ 8'h01}; // Foreign address bytes
  wire so_line = so_oe ? so : 1'b1; // Released output floats to the pull-up
  int cyc = 0;
  int error_cnt = 0;
  int samples_checked = 0;

  dpc_top #(.DEV_TYPE(TYPE_ID), .NV_CYCLES(NV), .SETTLE_CYCLES(SETTLE)) i_dpc_top (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .addr_pin(addr_pin), .so(so), .so_oe(so_oe), .wiper0(wiper0),
    .wiper1(wiper1), .write_pending(write_pending));
  dpc_spi_master i_dpc_spi_master (.so(so_line), .cs_n(cs_n), .sck(sck), .si(si));

  // Free-running 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle ceiling cuts a hung run short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  // Compares one byte-wide result
  task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
    samples_checked++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask

  // Prints the counts and the verdict
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One frame: address, instruction, then nb trailing bits taken from d
  task automatic cmd(input logic [7:0] a, input logic [3:0] op, input logic [1:0] sel, input logic pot,
    input int nb, input logic [7:0] d);
    i_dpc_spi_master.frame(16 + nb, {8'h00, a, op, sel, 1'b0, pot, d} >> (8 - nb), rx);
  endtask

  // Reads a register and compares it
  task automatic rd(input logic [3:0] op, input logic [1:0] sel, input logic pot, input logic [5:0] exp);
    cmd(ADDR, op, sel, pot, 8, BYTE_ZERO);
    check(rx, {2'b00, exp}, "read");
  endtask

  // Confirms a save is running, then polls status until it ends
  task automatic saved();
    check({7'h00, write_pending}, 8'h01, "pending");
    cmd(ADDR, OP_STATUS, SEL_ZERO, 1'b1, 8, BYTE_ZERO);
    check(rx, 8'h01, "status busy");
    for (int i = 0; i < 8 && rx[0] !== 1'b0; i++)
      cmd(ADDR, OP_STATUS, SEL_ZERO, 1'b1, 8, BYTE_ZERO);
    check(rx, BYTE_ZERO, "status idle");
  endtask

  // Main sequence
  initial
  begin
    rst <= 1'b1;
    addr_pin <= PINS;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (SETTLE + 20) @(posedge clk);
    // Sub-cycle offset keeps every later pin change and check clear of the clock edges
    #0.2;
    check({2'b00, wiper0}, 8'h20, "init w0");
    check({2'b00, wiper1}, 8'h20, "init w1");
    rd(OP_RD_SET, 2'h0, 1'b0, 6'h20);
    cmd(ADDR, OP_WR_WIPER, SEL_ZERO, 1'b1, 8, 8'h15);
    check({2'b00, wiper1}, 8'h15, "write w1");
    rd(OP_RD_WIPER, SEL_ZERO, 1'b1, 6'h15);
    cmd(ADDR, OP_WR_SET, 2'h2, 1'b0, 8, 8'h2A);
    saved();
    rd(OP_RD_SET, 2'h2, 1'b0, 6'h2A);
    cmd(ADDR, OP_SET_TO_WIPER, 2'h2, 1'b0, 0, BYTE_ZERO);
    check({2'b00, wiper0}, 8'h2A, "copy w0");
    cmd(ADDR, OP_WIPER_TO_SET, 2'h3, 1'b1, 0, BYTE_ZERO);
    saved();
    rd(OP_RD_SET, 2'h3, 1'b1, 6'h15);
    cmd(ADDR, OP_GLB_WIPER_TO_SET, 2'h1, 1'b0, 0, BYTE_ZERO);
    saved();
    rd(OP_RD_SET, 2'h1, 1'b0, 6'h2A);
    rd(OP_RD_SET, 2'h1, 1'b1, 6'h15);
    cmd(ADDR, OP_GLB_SET_TO_WIPER, SEL_ZERO, 1'b0, 0, BYTE_ZERO);
    check({2'b00, wiper0}, 8'h20, "global w0");
    check({2'b00, wiper1}, 8'h20, "global w1");
    cmd(ADDR, OP_WR_WIPER, SEL_ZERO, 1'b0, 8, 8'h3E);
    cmd(ADDR, OP_STEP, SEL_ZERO, 1'b0, 3, 8'hE0);
    check({2'b00, wiper0}, 8'h3F, "step up");
    cmd(ADDR, OP_WR_WIPER, SEL_ZERO, 1'b0, 8, 8'h01);
    cmd(ADDR, OP_STEP, SEL_ZERO, 1'b0, 3, BYTE_ZERO);
    check({2'b00, wiper0}, 8'h00, "step down");
    check({2'b00, wiper1}, 8'h20, "other pot");
    // Wiper write with a nonzero setting pointer must be ignored
    cmd(ADDR, OP_WR_WIPER, 2'h1, 1'b0, 8, 8'h11);
    check({2'b00, wiper0}, 8'h00, "bad pointer");
    // Foreign type, nonzero upper pair and wrong strap must all be ignored
    foreach (bad[i])
    begin
      cmd(bad[i], OP_WR_WIPER, SEL_ZERO, 1'b0, 8, 8'h11);
      check({2'b00, wiper0}, 8'h00, "refused");
    end
    end_of_test();
  end
endmodule
